// *** rtl/csm_ctrl.sv ***
// Contact sensor wake, button gesture, mode and telegram burst controller
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module csm_ctrl #(
  parameter int TICK_CYC = csm_pkg::TICK_CYC,
  parameter int STD_AIR_CYC = csm_pkg::STD_AIR_CYC,
  parameter int SEC_AIR_CYC = csm_pkg::SEC_AIR_CYC,
  parameter int GAP_MIN_CYC = csm_pkg::GAP_MIN_CYC,
  parameter int GAP_RND_BITS = csm_pkg::GAP_RND_BITS,
  parameter logic [11:0] MAKER_ID = 12'h5A3, // arbitrary value
  parameter logic [31:0] ID_RESET = 32'h0000_0001 // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nv_clear_n,
  input wire logic reed_pin,
  input wire logic teach_key_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic led,
  output logic sleep,
  output logic tx_air,
  output logic tx_secure,
  output csm_pkg::csm_kind_t tx_kind,
  output logic tx_contact,
  output logic tx_button,
  output logic [31:0] tx_id,
  output logic [23:0] tx_rlc,
  output logic [35:0] tx_aux,
  output logic [7:0] tx_checksum
);
  import csm_pkg::*;

  localparam int STD_WIN_CYC = STD_WIN_MS * 1000 * CYC_PER_US;
  localparam int SEC_WIN_CYC = SEC_WIN_MS * 1000 * CYC_PER_US;
  localparam int GAP_MAX_CYC = GAP_MIN_CYC + (1 << GAP_RND_BITS) - 1;

  if (TICK_CYC < 2 || STD_AIR_CYC < 1 || SEC_AIR_CYC < 1 || GAP_RND_BITS < 1 || GAP_RND_BITS > 24 ||
      STD_SUBS * STD_AIR_CYC + (STD_SUBS - 1) * GAP_MAX_CYC > STD_WIN_CYC ||
      SEC_SUBS * SEC_AIR_CYC + (SEC_SUBS - 1) * GAP_MAX_CYC > SEC_WIN_CYC)
  begin : g_chk
    $error("burst timing does not fit its window");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [31:0] air_cyc(input logic sec);
    return sec ? 32'(SEC_AIR_CYC) : 32'(STD_AIR_CYC);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic reed_meta_r, reed_r, reed_prev_r;
  logic key_meta_r, key_r, key_prev_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [23:0] lfsr_r;

  // Pins are asynchronous; nothing looks at the first stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reed_meta_r <= 1'b0;
      reed_r <= 1'b0;
      reed_prev_r <= 1'b0;
      key_meta_r <= 1'b0;
      key_r <= 1'b0;
      key_prev_r <= 1'b0;
    end
    else
    begin
      reed_meta_r <= reed_pin;
      reed_r <= reed_meta_r;
      reed_prev_r <= reed_r;
      key_meta_r <= teach_key_pin;
      key_r <= key_meta_r;
      key_prev_r <= key_r;
    end
  end

  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end

  // Source of the random gaps and status intervals
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lfsr_r <= LFSR_SEED;
    else
      lfsr_r <= {lfsr_r[22:0], lfsr_r[23] ^ lfsr_r[22] ^ lfsr_r[21] ^ lfsr_r[16]};
  end

  ////////////////////////////////////////////////////////////////////////////
  csm_mode_t nv_mode;
  logic [5:0] nv_changes;
  logic [23:0] nv_rlc;
  logic [6:0] press_r;
  logic [3:0] pause_r;
  logic long_wait_r;
  csm_act_t act_r;
  logic is_short, is_long;

  assign is_short = press_r >= 7'(SHORT_MIN_T) && press_r < 7'(SHORT_MAX_T);
  assign is_long = press_r >= 7'(SHORT_MAX_T) && press_r <= 7'(LONG_MAX_T);

  // Press length in ticks; releases are classified into mode actions
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      press_r <= 7'h00;
      pause_r <= 4'h0;
      long_wait_r <= 1'b0;
      act_r <= ACT_NONE;
    end
    else
    begin
      act_r <= ACT_NONE;
      if (key_r && !key_prev_r)
        press_r <= 7'h00;
      else if (key_r && tick && press_r != 7'h7F)
        press_r <= press_r + 7'h01;
      if (key_prev_r && !key_r)
      begin
        long_wait_r <= 1'b0;
        if (is_short && !long_wait_r)
          act_r <= (nv_mode == MODE_TRN) ? ACT_TO_STD : ACT_TEACH;
        else if (is_long && nv_mode == MODE_SEC)
          act_r <= ACT_TO_TRN;
        else if (is_long && nv_mode == MODE_STD && long_wait_r)
          act_r <= ACT_TO_SEC;
        else if (is_long && nv_mode == MODE_STD)
        begin
          long_wait_r <= 1'b1;
          pause_r <= 4'h0;
        end
      end
      else if (long_wait_r && !key_r && tick)
      begin
        // A lone long press is only known once the pause runs out
        if (pause_r == 4'(PAUSE_MAX_T - 1))
        begin
          long_wait_r <= 1'b0;
          act_r <= ACT_TO_TRN;
        end
        else
          pause_r <= pause_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  csm_state_t state_r;
  logic [31:0] ctrl_r;
  logic [31:0] id_reg;
  csm_act_t pend_act_r;
  logic pend_contact_r, pend_status_r;
  logic [14:0] status_r;
  logic [12:0] span;
  logic wake, serve_act, go, go_sec, go_follow, mode_wr, rlc_inc, follow_go;
  csm_kind_t go_kind;
  csm_mode_t mode_val;
  logic [2:0] go_flash;
  logic [31:0] timer_r;
  logic [1:0] sub_r;
  logic follow_r;
  logic [2:0] halves_r;
  logic last_sub;

  assign wake = state_r == ST_SLEEP && (pend_act_r != ACT_NONE || pend_contact_r || pend_status_r);
  assign serve_act = wake && pend_act_r != ACT_NONE;
  assign span = (lfsr_r[12:0] > 13'(STATUS_SPAN_T)) ? lfsr_r[12:0] - 13'h1000 : lfsr_r[12:0];

  // A new event in the cycle it is served stays pending
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_act_r <= ACT_NONE;
      pend_contact_r <= 1'b0;
      pend_status_r <= 1'b0;
    end
    else
    begin
      if (act_r != ACT_NONE)
        pend_act_r <= act_r;
      else if (serve_act)
        pend_act_r <= ACT_NONE;
      if (reed_r != reed_prev_r)
        pend_contact_r <= 1'b1;
      else if (wake && !serve_act)
        pend_contact_r <= 1'b0;
      if (tick && status_r == 15'h0001 && ctrl_r[CTRL_STATUS_EN] && nv_mode != MODE_TRN)
        pend_status_r <= 1'b1;
      else if (wake && !serve_act)
        pend_status_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_r <= 15'(STATUS_MIN_T);
    else if (wake)
      status_r <= 15'(STATUS_MIN_T) + 15'(span);
    else if (tick && status_r != 15'h0000)
      status_r <= status_r - 15'h0001;
  end

  always_comb
  begin
    go = 1'b0;
    go_sec = 1'b0;
    go_follow = 1'b0;
    go_kind = KIND_DATA;
    go_flash = 3'h0;
    mode_wr = 1'b0;
    mode_val = nv_mode;
    if (serve_act)
    begin
      case (pend_act_r)
        ACT_TEACH:
        begin
          go = nv_mode != MODE_TRN;
          go_sec = nv_mode == MODE_SEC;
          go_follow = go_sec;
          go_kind = go_sec ? KIND_SEC_KEY : KIND_TEACH_STD;
        end
        ACT_TO_STD, ACT_TO_SEC, ACT_TO_TRN:
        begin
          // Once the store is worn out the press is ignored
          go = nv_changes < 6'(CHANGE_LIMIT);
          mode_wr = go;
          mode_val = pend_act_r == ACT_TO_STD ? MODE_STD : pend_act_r == ACT_TO_SEC ? MODE_SEC : MODE_TRN;
          go_sec = pend_act_r == ACT_TO_SEC;
          go_follow = go_sec;
          go_kind = pend_act_r == ACT_TO_STD ? KIND_TEACH_STD : go_sec ? KIND_SEC_KEY : KIND_SIGNAL;
          go_flash = pend_act_r == ACT_TO_TRN ? 3'(FLASH_TRN) : 3'(FLASH_STD);
        end
        default:
        begin
          go = 1'b0;
        end
      endcase
    end
    else if (wake)
    begin
      go = nv_mode != MODE_TRN;
      go_sec = nv_mode == MODE_SEC;
    end
  end

  assign last_sub = sub_r == (tx_secure ? 2'(SEC_SUBS - 1) : 2'(STD_SUBS - 1));
  assign follow_go = state_r == ST_GAP && timer_r == 32'h0000_0000 && last_sub;
  assign rlc_inc = (go && go_sec) || follow_go;

  csm_nvstore #(.LIMIT(CHANGE_LIMIT)) u_nv (
    .aclk(aclk),
    .clear_n(nv_clear_n),
    .mode_wr(mode_wr),
    .mode_in(mode_val),
    .rlc_inc(rlc_inc),
    .mode_r(nv_mode),
    .changes_r(nv_changes),
    .rlc_r(nv_rlc)
  );

  assign tx_rlc = nv_rlc;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_SLEEP;
      tx_air <= 1'b0;
      tx_secure <= 1'b0;
      tx_kind <= KIND_DATA;
      tx_contact <= 1'b0;
      tx_button <= 1'b0;
      tx_aux <= 36'h0;
      tx_checksum <= 8'h00;
      timer_r <= 32'h0000_0000;
      sub_r <= 2'h0;
      follow_r <= 1'b0;
      halves_r <= 3'h0;
    end
    else
    begin
      case (state_r)
        ST_SLEEP:
          if (go)
          begin
            state_r <= ST_AIR;
            tx_air <= 1'b1;
            tx_secure <= go_sec;
            tx_kind <= go_kind;
            tx_contact <= reed_r;
            tx_button <= key_r;
            tx_aux <= go_kind == KIND_SIGNAL ? {28'h0, SIGNAL_TRANSPORT} :
                      go_kind == KIND_DATA ? 36'h0 : {MAKER_ID, PROFILE_CODE};
            tx_checksum <= tx_id[31:24] + tx_id[23:16] + tx_id[15:8] + tx_id[7:0] +
                           {3'h0, go_kind, key_r, reed_r};
            timer_r <= air_cyc(go_sec) - 32'h0000_0001;
            sub_r <= 2'h0;
            follow_r <= go_follow;
            halves_r <= 3'(2 * go_flash);
          end
        ST_AIR:
          if (timer_r != 32'h0000_0000)
            timer_r <= timer_r - 32'h0000_0001;
          else
          begin
            tx_air <= 1'b0;
            timer_r <= 32'(GAP_MIN_CYC) + 32'(lfsr_r & 24'((1 << GAP_RND_BITS) - 1));
            if (!last_sub || follow_r)
              state_r <= ST_GAP;
            else
              state_r <= halves_r != 3'h0 ? ST_FLASH : ST_SLEEP;
          end
        ST_GAP:
          if (timer_r != 32'h0000_0000)
            timer_r <= timer_r - 32'h0000_0001;
          else
          begin
            state_r <= ST_AIR;
            tx_air <= 1'b1;
            timer_r <= air_cyc(tx_secure) - 32'h0000_0001;
            sub_r <= last_sub ? 2'h0 : sub_r + 2'h1;
            if (last_sub)
            begin
              // Key telegram done; the profile one follows, secured
              follow_r <= 1'b0;
              tx_kind <= KIND_SEC_PROF;
            end
          end
        ST_FLASH:
          if (halves_r == 3'h0)
            state_r <= ST_SLEEP;
          else if (tick)
            halves_r <= halves_r - 3'h1;
        default:
          state_r <= ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led <= 1'b0;
      sleep <= 1'b1;
    end
    else
    begin
      led <= tx_air || (state_r == ST_FLASH && halves_r != 3'h0 && !halves_r[0]);
      sleep <= state_r == ST_SLEEP && !wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] rd_data;
  logic rd_ok;

  assign tx_id = id_reg;

  // Address and data are taken together, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_r <= CTRL_RESET;
      id_reg <= ID_RESET;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        case (s_axi_awaddr)
          REG_CTRL: ctrl_r <= merge(ctrl_r, s_axi_wdata, s_axi_wstrb) & CTRL_RESET;
          REG_ID: id_reg <= merge(id_reg, s_axi_wdata, s_axi_wstrb);
          REG_STATUS, REG_RLC: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      REG_CTRL: rd_data = ctrl_r;
      REG_ID: rd_data = id_reg;
      REG_STATUS:
      begin
        rd_data[ST_MODE_LSB +: 2] = nv_mode;
        rd_data[ST_REED] = reed_r;
        rd_data[ST_KEY] = key_r;
        rd_data[ST_FSM_LSB +: 2] = state_r;
        rd_data[ST_COUNT_LSB +: 6] = nv_changes;
      end
      REG_RLC: rd_data = {8'h00, nv_rlc};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] air_len_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      air_len_r <= 32'h0000_0000;
    else
      air_len_r <= tx_air ? air_len_r + 32'h0000_0001 : 32'h0000_0000;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  led_on_air_a: assert property (tx_air |=> led)
    else $error("LED dark during transmission");
  sleep_quiet_a: assert property (sleep |-> !tx_air && state_r == ST_SLEEP)
    else $error("asleep while transmitting");
  std_burst_a: assert property (tx_air && !tx_secure |-> sub_r < 2'(STD_SUBS))
    else $error("too many standard sub-telegrams");
  sec_burst_a: assert property (tx_air && tx_secure |-> sub_r < 2'(SEC_SUBS))
    else $error("too many secure sub-telegrams");
  air_length_a: assert property ($fell(tx_air) |-> air_len_r == air_cyc($past(tx_secure)))
    else $error("sub-telegram airtime wrong");
  change_cap_a: assert property (nv_changes <= 6'(CHANGE_LIMIT))
    else $error("mode change limit exceeded");
  rlc_step_a: assert property ($changed(nv_rlc) |-> nv_rlc == $past(nv_rlc) + 24'h000001)
    else $error("rolling counter jumped");
  transport_signal_a: assert property ($rose(tx_air) && nv_mode == MODE_TRN |-> tx_kind == KIND_SIGNAL)
    else $error("transport mode sent a non-signal telegram");
  signal_code_a: assert property (tx_air && tx_kind == KIND_SIGNAL |-> tx_aux[7:0] == SIGNAL_TRANSPORT)
    else $error("signal code wrong");
  secure_follow_a: assert property ($rose(tx_air) && tx_kind == KIND_SEC_KEY |-> follow_r && tx_secure)
    else $error("key teach not followed by profile teach");
endmodule
`default_nettype wire

// *** rtl/csm_nvstore.sv ***
// Non-volatile mode, change count and rolling counter store
`timescale 1ns/10ps
`default_nettype none
module csm_nvstore #(
  parameter int LIMIT = csm_pkg::CHANGE_LIMIT
) (
  input wire logic aclk,
  input wire logic clear_n,
  input wire logic mode_wr,
  input wire csm_pkg::csm_mode_t mode_in,
  input wire logic rlc_inc,
  output csm_pkg::csm_mode_t mode_r,
  output logic [5:0] changes_r,
  output logic [23:0] rlc_r
);
  import csm_pkg::*;

  if (LIMIT < 1 || LIMIT > 63)
  begin : g_chk
    $error("change limit must fit six bits");
  end

  // Only the factory clear touches this store; a system reset leaves it alone
  always_ff @(posedge aclk)
  begin
    if (!clear_n)
    begin
      mode_r <= MODE_TRN;
      changes_r <= 6'h00;
    end
    else if (mode_wr && changes_r < 6'(LIMIT))
    begin
      mode_r <= mode_in;
      changes_r <= changes_r + 6'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!clear_n)
      rlc_r <= 24'h000000;
    else if (rlc_inc)
      rlc_r <= rlc_r + 24'h000001;
  end
endmodule
`default_nettype wire

// *** rtl/csm_pkg.sv ***
// Constants and types for the contact sensor mode and telegram controller
// Behaviour
// - Input change or key press sends telegram now
// - Status telegram every random 20-30 minutes
// - LED pulses during every transmission
// - Sleep between wake-up events
// - Teach telegram form follows current mode
// - Teach telegram carries maker and profile codes
// - Ships in transport mode
// - Transport plus short press: standard, two flashes
// - Standard plus two long presses: secure
// - Long press: transport, signal, three flashes
// - Short press lasts 0.1 to 3.0 s
// - Long press lasts 3 to 7 s
// - Mode survives power-down in non-volatile store
// - At most 50 mode changes ever
// - Secure: 24-bit counter, 3-byte code, cipher; only the counter (tx_rlc) is made here, no code or cipher
// - Secure wraps unchanged standard payload
// - Secure teach: key telegram then profile telegram
// - Standard: three sub-telegrams within 40 ms
// - Standard sub-telegram lasts about 0.9 ms
// - Secure: two 1.2 ms sub-telegrams within 20 ms
// - Transport signal telegram carries code 0x0E
// - Counter steps per secure telegram, kept
package csm_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int SHORT_MIN_MS = 100;
  localparam int SHORT_MAX_MS = 3000;
  localparam int LONG_MAX_MS = 7000;
  localparam int PAUSE_MAX_MS = 1000;
  localparam int SHORT_MIN_T = (SHORT_MIN_MS + TICK_MS - 1) / TICK_MS;
  localparam int SHORT_MAX_T = SHORT_MAX_MS / TICK_MS;
  localparam int LONG_MAX_T = LONG_MAX_MS / TICK_MS;
  localparam int PAUSE_MAX_T = PAUSE_MAX_MS / TICK_MS;
  localparam int STATUS_MIN_MIN = 20;
  localparam int STATUS_MAX_MIN = 30;
  localparam int STATUS_MIN_T = STATUS_MIN_MIN * 60_000 / TICK_MS;
  localparam int STATUS_SPAN_T = (STATUS_MAX_MIN - STATUS_MIN_MIN) * 60_000 / TICK_MS;
  localparam int STD_AIR_US = 900;
  localparam int SEC_AIR_US = 1200;
  localparam int STD_AIR_CYC = STD_AIR_US * CYC_PER_US;
  localparam int SEC_AIR_CYC = SEC_AIR_US * CYC_PER_US;
  localparam int STD_WIN_MS = 40;
  localparam int SEC_WIN_MS = 20;
  localparam int STD_SUBS = 3;
  localparam int SEC_SUBS = 2;
  localparam int GAP_MIN_US = 1000;
  localparam int GAP_MIN_CYC = GAP_MIN_US * CYC_PER_US;
  localparam int GAP_RND_BITS = 17;
  localparam int FLASH_STD = 2;
  localparam int FLASH_TRN = 3;
  localparam int CHANGE_LIMIT = 50;
  localparam logic [7:0] SIGNAL_TRANSPORT = 8'h0E;
  localparam logic [23:0] PROFILE_CODE = 24'hD50001;
  localparam logic [23:0] LFSR_SEED = 24'hA5C3E1;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ID = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RLC = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_STATUS_EN = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_REED = 4;
  localparam int ST_KEY = 5;
  localparam int ST_FSM_LSB = 8;
  localparam int ST_COUNT_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MODE_STD = 2'h1, MODE_SEC = 2'h2, MODE_TRN = 2'h3} csm_mode_t;
  typedef enum logic [2:0] {KIND_DATA = 3'h0, KIND_TEACH_STD = 3'h1, KIND_SEC_KEY = 3'h2,
                            KIND_SEC_PROF = 3'h3, KIND_SIGNAL = 3'h4} csm_kind_t;
  typedef enum logic [2:0] {ACT_NONE = 3'h0, ACT_TEACH = 3'h1, ACT_TO_STD = 3'h2,
                            ACT_TO_SEC = 3'h3, ACT_TO_TRN = 3'h4} csm_act_t;
  typedef enum logic [1:0] {ST_SLEEP = 2'h0, ST_AIR = 2'h1, ST_GAP = 2'h3, ST_FLASH = 2'h2} csm_state_t;
endpackage

// *** testbench/contact_sensor_mode_and_telegram_control_bench.sv ***
// Self-checking bench for the contact sensor controller
`timescale 1ns/10ps
`default_nettype none
module contact_sensor_mode_and_telegram_control_bench;
  import csm_pkg::*;
  localparam int TK = 10;
  localparam logic [11:0] MK = 12'h2C7; // arbitrary value
  localparam logic [31:0] ID_RST = 32'h0000_0001; // arbitrary value
  localparam logic [31:0] M = 32'hFFFF_FFFF;
  localparam logic [31:0] ST = 32'h003F_0003;
  localparam logic [35:0] TA = {MK, PROFILE_CODE};
  logic aclk = 1'b0, aresetn = 1'b0, nv_clear_n = 1'b0, reed_pin = 1'b0, teach_key_pin = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, idv, lfsr = 32'h0000_E33E;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, led, sleep, tx_air, tx_secure;
  logic tx_contact, tx_button, sec_learned;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tx_id;
  logic [23:0] tx_rlc;
  logic [35:0] tx_aux;
  logic [7:0] tx_checksum;
  csm_kind_t tx_kind;
  int bad_count = 0, cmp_count = 0, subs, air_len, refused, s0;
  csm_ctrl #(.TICK_CYC(TK), .STD_AIR_CYC(9), .SEC_AIR_CYC(12), .GAP_MIN_CYC(4), .GAP_RND_BITS(3), .MAKER_ID(MK),
    .ID_RESET(ID_RST)) csm_ctrl_i (.aclk, .aresetn, .nv_clear_n, .reed_pin, .teach_key_pin, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .led, .sleep, .tx_air, .tx_secure, .tx_kind, .tx_contact, .tx_button, .tx_id,
    .tx_rlc, .tx_aux, .tx_checksum);
  csm_rx_model csm_rx_model_i (.aclk, .tx_air, .tx_secure, .tx_kind, .subs, .air_len, .refused, .sec_learned);
  initial
  begin
    forever #20 aclk = ~aclk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Data telegram: kind and button are zero, only the contact bit adds
  function automatic logic [7:0] csum(input logic [31:0] id, input logic c);
    return id[31:24] + id[23:16] + id[15:8] + id[7:0] + {7'h00, c};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, er);
    check(s_axi_rdata & m, e);
  endtask
  task automatic press(input int ticks);
    teach_key_pin <= 1'b1;
    repeat (ticks * TK) @(posedge aclk);
    teach_key_pin <= 1'b0;
  endtask
  task automatic burst(input int n, input int len, input csm_kind_t k, input logic [35:0] ax, input logic ck,
                       input logic sc);
    s0 = subs;
    do @(posedge aclk); while (tx_air !== 1'b1);
    check(tx_kind, k);
    check(tx_aux, ax);
    if (ck)
    begin
      check(tx_secure, sc);
      check(tx_checksum, csum(idv, reed_pin));
      check(tx_contact, reed_pin);
      check(tx_button, 1'b0);
      check(tx_id, idv);
    end
    @(posedge aclk);
    check(led, 1'b1);
    do @(posedge aclk); while (sleep !== 1'b1);
    check(subs - s0, n);
    check(air_len, len);
  endtask
  task automatic tdone(input string n);
    $display("test %s done, mismatches %0d", n, bad_count);
  endtask
  initial
  begin
    repeat (80000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    idv = ID_RST;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    nv_clear_n <= 1'b1;
    axr(REG_CTRL, RESP_OKAY, M, 32'h0000_0001);
    axr(REG_STATUS, RESP_OKAY, ST, 32'h0000_0003);
    axr(8'h10, RESP_SLVERR, M, 32'h0000_0000);
    axw(8'h14, M, RESP_SLVERR);
    axw(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    lfsr = nxt(lfsr);
    idv = lfsr;
    axw(REG_ID, idv, RESP_OKAY);
    axr(REG_ID, RESP_OKAY, M, idv);
    tdone("registers");
    press(10);
    burst(3, 9, KIND_TEACH_STD, TA, 1'b0, 1'b0);
    axr(REG_STATUS, RESP_OKAY, ST, 32'h0001_0001);
    lfsr = nxt(lfsr);
    repeat (lfsr[5:0]) @(posedge aclk);
    reed_pin <= 1'b1;
    burst(3, 9, KIND_DATA, 36'h0_0000_0000, 1'b1, 1'b0);
    tdone("standard");
    press(50);
    repeat (3 * TK) @(posedge aclk);
    press(50);
    burst(4, 12, KIND_SEC_KEY, TA, 1'b0, 1'b0);
    check(sec_learned, 1'b1);
    check(refused, 0);
    axr(REG_STATUS, RESP_OKAY, ST, 32'h0002_0002);
    reed_pin <= 1'b0;
    burst(2, 12, KIND_DATA, 36'h0_0000_0000, 1'b1, 1'b1);
    press(10);
    burst(4, 12, KIND_SEC_KEY, TA, 1'b0, 1'b0);
    check(tx_rlc, 24'h000005);
    tdone("secure");
    // Power-down style reset must keep mode and counter
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    idv = ID_RST;
    axw(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    axr(REG_STATUS, RESP_OKAY, ST, 32'h0002_0002);
    axr(REG_RLC, RESP_OKAY, M, 32'h0000_0005);
    press(50);
    burst(3, 9, KIND_SIGNAL, 36'h0_0000_000E, 1'b0, 1'b0);
    axr(REG_STATUS, RESP_OKAY, ST, 32'h0003_0003);
    s0 = subs;
    press(80);
    repeat (20 * TK) @(posedge aclk);
    check(subs, s0);
    axr(REG_STATUS, RESP_OKAY, ST, 32'h0003_0003);
    tdone("transport");
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** testbench/csm_rx_model.sv ***
// Receiver model that counts, times and learns sensor sub-telegrams
`timescale 1ns/10ps
`default_nettype none
module csm_rx_model (
  input wire logic aclk,
  input wire logic tx_air,
  input wire logic tx_secure,
  input wire csm_pkg::csm_kind_t tx_kind,
  output int subs,
  output int air_len,
  output int refused,
  output logic sec_learned
);
  import csm_pkg::*;
  int run;
  logic learned = 1'b0;
  assign sec_learned = learned;
  always @(posedge aclk)
  begin
    if (tx_air)
      run <= run + 1;
    else if (run != 0)
    begin
      air_len <= run;
      run <= 0;
    end
    if (tx_air && run == 0)
    begin
      subs <= subs + 1;
      // Secured traffic before the key telegram is thrown away
      if (tx_kind === KIND_SEC_KEY)
        learned <= 1'b1;
      else if (tx_secure && !learned)
        refused <= refused + 1;
    end
  end
endmodule
`default_nettype wire
